// file: logic/level_alarm_pkg.sv
// Shared constants and types for the level alarm and fill controller
package level_alarm_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          CLK_PERIOD_NS = 4;
  localparam int          TICK_NS       = 1000000;           // 1 ms tick
  localparam int          TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
  localparam logic [15:0] STARTUP_MS    = 16'h03e8;          // 1000 ms
  localparam logic [15:0] SLOW_MS       = 16'h01f4;          // 500 ms step
  localparam logic [15:0] FAST_MS       = 16'h0032;          // 50 ms step
  localparam logic [15:0] ACCEL_MS      = 16'h07d0;          // 2000 ms hold
  localparam logic [15:0] SHOW_MS       = 16'h07d0;          // 2000 ms
  localparam logic [15:0] FAULT_MS      = 16'h0bb8;          // 3000 ms
  localparam logic [15:0] MS_PER_MIN    = 16'hea60;          // 60000 ms

  // ----------------------------------------------------------------
  // Scales and reset values
  // ----------------------------------------------------------------
  localparam logic [9:0]  FULL_SCALE    = 10'h3e8;           // 100.0 %
  localparam logic [9:0]  INTERVAL_MAX  = 10'h258;           // 600 min
  localparam logic [15:0] SPAN_MIN      = 16'h0001;
  localparam logic [15:0] SPAN_MAX      = 16'h270f;
  localparam logic [15:0] SPAN_RESET    = 16'h0064;
  localparam logic [9:0]  UP_RESET      = 10'h384;
  localparam logic [9:0]  BOT_RESET     = 10'h064;
  localparam logic [9:0]  STOP_RESET    = 10'h320;
  localparam logic [9:0]  START_RESET   = 10'h0c8;
  localparam logic [9:0]  INTERVAL_RST  = 10'h000;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [4:0]  OFS_SPAN      = 5'h00;
  localparam logic [4:0]  OFS_UPPER     = 5'h04;
  localparam logic [4:0]  OFS_BOTTOM    = 5'h08;
  localparam logic [4:0]  OFS_STOP      = 5'h0c;
  localparam logic [4:0]  OFS_START     = 5'h10;
  localparam logic [4:0]  OFS_INTERVAL  = 5'h14;
  localparam logic [4:0]  OFS_STATUS    = 5'h18;
  localparam logic [4:0]  OFS_LEVEL     = 5'h1c;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {MODE_RUN, MODE_SILENCE, MODE_SPAN, MODE_UPPER,
                            MODE_BOTTOM, MODE_STOP, MODE_START,
                            MODE_INTERVAL} mode_t;
  typedef enum logic [1:0] {UNIT_PCT, UNIT_INCH, UNIT_CM} unit_t;
  typedef enum logic [1:0] {FILL_CLOSED, FILL_OPEN, FILL_AUTO} fill_sel_t;
  typedef enum logic [1:0] {FILL_IDLE, FILL_ON, FILL_LOCK} fill_state_t;

  typedef struct packed {
    mode_t     mode;
    unit_t     unit;
    fill_sel_t fill;
    logic      raise;
    logic      lower;
  } panel_t;

  typedef struct packed {
    logic fault;
    logic lockout;
    logic valve;
    logic buzzer;
    logic bottom;
    logic upper;
  } flags_t;

endpackage : level_alarm_pkg

// file: logic/level_alarm_fill_controller.sv
// Level alarm, fill control and front-panel adjustment logic
module level_alarm_fill_controller #(
  parameter int TICK_CYCLES = level_alarm_pkg::TICK_CYCLES
) (
  input  wire logic                    clk,
  input  wire logic                    reset_n,
  input  wire level_alarm_pkg::panel_t panel,
  input  wire logic                    level_valid,
  input  wire logic [9:0]              level,
  input  wire logic                    nv_restore,
  input  wire logic [15:0]             nv_restore_span,
  input  wire logic [4:0]              address,
  input  wire logic                    read,
  input  wire logic                    write,
  input  wire logic [31:0]             writedata,
  output logic [31:0]                  readdata,
  output logic                         waitrequest,
  output logic [15:0]                  display_value,
  output logic                         display_startup,
  output logic                         display_flash,
  output logic                         activity_led,
  output logic                         upper_alarm_indicator,
  output logic                         bottom_alarm_indicator,
  output logic                         upper_relay_coil,
  output logic                         bottom_relay_coil,
  output logic                         fill_stop_indicator,
  output logic                         fill_start_indicator,
  output logic                         fill_indicator,
  output logic                         fill_valve,
  output logic                         buzzer,
  output logic                         nv_write,
  output logic [15:0]                  nv_span
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    level_alarm_pkg::panel_t      s1;
    level_alarm_pkg::panel_t      s2;
    logic [9:0]                   lvl;
    logic [15:0]                  span;
    logic [9:0]                   up_thr;
    logic [9:0]                   bot_thr;
    logic [9:0]                   stop_thr;
    logic [9:0]                   start_thr;
    logic [9:0]                   interval;
    logic [31:0]                  tick;
    logic                         tick_p;
    logic [15:0]                  boot_ms;
    logic [15:0]                  quiet_ms;
    logic [15:0]                  hold_ms;
    logic [15:0]                  step_ms;
    logic [15:0]                  show_ms;
    logic [15:0]                  min_ms;
    logic [9:0]                   min_left;
    level_alarm_pkg::fill_state_t fst;
    logic                         waitreq;
    logic [31:0]                  rdata;
    logic [15:0]                  disp;
    logic                         startup;
    logic                         flash;
    logic                         act;
    logic                         up_ind;
    logic                         bot_ind;
    logic                         up_coil;
    logic                         bot_coil;
    logic                         stop_ind;
    logic                         start_ind;
    logic                         fill_ind;
    logic                         valve;
    logic                         buzz;
    logic                         nvw;
  } state_t;

  state_t st;
  state_t nxt;

  // One panel step on a 10-bit setting, clamped to 0..max
  function automatic logic [9:0] bump(input logic [9:0] v, input logic up,
                                      input logic [9:0] max);
    logic [9:0] r;
    r = v;
    if (up && v < max) r = v + 10'h001;
    else if (!up && v != 10'h000) r = v - 10'h001;
    return r;
  endfunction : bump

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic                    sw;
    logic                    up;
    logic                    step;
    logic                    fault;
    logic                    req;
    logic [9:0]              nv;
    logic [15:0]             per;
    logic [25:0]             prod;
    level_alarm_pkg::flags_t fl;
    sw    = 1'b0;
    up    = 1'b0;
    step  = 1'b0;
    fault = 1'b0;
    req   = 1'b0;
    nv    = 10'h000;
    per   = 16'h0000;
    prod  = 26'h0000000;
    fl    = '0;
    nxt   = st;
    nxt.s1 = panel;
    nxt.s2 = st.s1;

    // Millisecond tick prescaler
    nxt.tick_p = 1'b0;
    if (st.tick == 32'(TICK_CYCLES - 1)) begin
      nxt.tick   = 32'h00000000;
      nxt.tick_p = 1'b1;
    end else begin
      nxt.tick = st.tick + 32'h00000001;
    end

    // Startup pattern timer
    if (st.tick_p && st.boot_ms != level_alarm_pkg::STARTUP_MS) begin
      nxt.boot_ms = st.boot_ms + 16'h0001;
    end
    nxt.startup = nxt.boot_ms != level_alarm_pkg::STARTUP_MS;

    // Reading watchdog and activity blink
    if (level_valid) begin
      nxt.quiet_ms = 16'h0000;
      nxt.act      = ~st.act;
    end else if (st.tick_p && st.quiet_ms != level_alarm_pkg::FAULT_MS) begin
      nxt.quiet_ms = st.quiet_ms + 16'h0001;
    end
    fault = nxt.quiet_ms == level_alarm_pkg::FAULT_MS;

    // Threshold compares on each new measurement
    if (level_valid) begin
      nxt.lvl       = level;
      nxt.up_ind    = level > st.up_thr;
      nxt.bot_ind   = level < st.bot_thr;
      nxt.stop_ind  = level >= st.stop_thr;
      nxt.start_ind = level < st.start_thr;
    end
    // Energised coil holds contacts open; no power leaves both closed
    nxt.up_coil  = !nxt.up_ind;
    nxt.bot_coil = !nxt.bot_ind;
    nxt.buzz = (nxt.up_ind || nxt.bot_ind) &&
               st.s2.mode != level_alarm_pkg::MODE_SILENCE;

    // Raise/lower hold timing with acceleration
    sw = st.s2.raise ^ st.s2.lower;
    up = st.s2.raise;
    if (!sw) begin
      nxt.hold_ms = 16'h0000;
      nxt.step_ms = 16'h0000;
    end else if (st.tick_p) begin
      if (st.hold_ms != level_alarm_pkg::ACCEL_MS) nxt.hold_ms = st.hold_ms + 16'h0001;
      per = (st.hold_ms == level_alarm_pkg::ACCEL_MS) ? level_alarm_pkg::FAST_MS :
            level_alarm_pkg::SLOW_MS;
      if (16'(st.step_ms + 16'h0001) >= per) begin
        nxt.step_ms = 16'h0000;
        step        = 1'b1;
      end else begin
        nxt.step_ms = st.step_ms + 16'h0001;
      end
    end

    // Momentary span display; a brief push never reaches a step
    if (sw && st.s2.mode == level_alarm_pkg::MODE_SPAN &&
        st.s2.unit != level_alarm_pkg::UNIT_PCT) begin
      nxt.show_ms = level_alarm_pkg::SHOW_MS;
    end else if (st.tick_p && st.show_ms != 16'h0000) begin
      nxt.show_ms = st.show_ms - 16'h0001;
    end

    // Panel adjustment of the selected setting
    if (step) begin
      case (st.s2.mode)
        level_alarm_pkg::MODE_SPAN: begin
          if (st.s2.unit != level_alarm_pkg::UNIT_PCT) begin
            if (up && st.span < level_alarm_pkg::SPAN_MAX) nxt.span = st.span + 16'h0001;
            else if (!up && st.span > level_alarm_pkg::SPAN_MIN) nxt.span = st.span - 16'h0001;
          end
        end
        level_alarm_pkg::MODE_UPPER: begin
          nxt.up_thr = bump(st.up_thr, up, level_alarm_pkg::FULL_SCALE);
        end
        level_alarm_pkg::MODE_BOTTOM: begin
          nxt.bot_thr = bump(st.bot_thr, up, level_alarm_pkg::FULL_SCALE);
        end
        level_alarm_pkg::MODE_STOP: begin
          nv = bump(st.stop_thr, up, level_alarm_pkg::FULL_SCALE);
          if (nv > st.start_thr) nxt.stop_thr = nv;
        end
        level_alarm_pkg::MODE_START: begin
          nv = bump(st.start_thr, up, level_alarm_pkg::FULL_SCALE);
          if (nv < st.stop_thr) nxt.start_thr = nv;
        end
        level_alarm_pkg::MODE_INTERVAL: begin
          nxt.interval = bump(st.interval, up, level_alarm_pkg::INTERVAL_MAX);
        end
        default: begin
        end
      endcase
    end

    // Avalon slave: one wait cycle, then answer
    req = read || write;
    nxt.waitreq = !(req && st.waitreq);
    fl = '{fault, st.fst == level_alarm_pkg::FILL_LOCK, st.valve, st.buzz,
           st.bot_ind, st.up_ind};
    if (req && st.waitreq) begin
      case (address)
        level_alarm_pkg::OFS_SPAN:     nxt.rdata = {16'h0000, st.span};
        level_alarm_pkg::OFS_UPPER:    nxt.rdata = {22'h000000, st.up_thr};
        level_alarm_pkg::OFS_BOTTOM:   nxt.rdata = {22'h000000, st.bot_thr};
        level_alarm_pkg::OFS_STOP:     nxt.rdata = {22'h000000, st.stop_thr};
        level_alarm_pkg::OFS_START:    nxt.rdata = {22'h000000, st.start_thr};
        level_alarm_pkg::OFS_INTERVAL: nxt.rdata = {22'h000000, st.interval};
        level_alarm_pkg::OFS_STATUS:   nxt.rdata = {26'h0000000, fl};
        level_alarm_pkg::OFS_LEVEL:    nxt.rdata = {22'h000000, st.lvl};
        default:                       nxt.rdata = 32'h00000000;
      endcase
    end
    if (write && !st.waitreq) begin
      nv = writedata[9:0];
      case (address)
        level_alarm_pkg::OFS_SPAN: begin
          if (writedata[15:0] >= level_alarm_pkg::SPAN_MIN &&
              writedata[15:0] <= level_alarm_pkg::SPAN_MAX) nxt.span = writedata[15:0];
        end
        level_alarm_pkg::OFS_UPPER: begin
          if (nv <= level_alarm_pkg::FULL_SCALE) nxt.up_thr = nv;
        end
        level_alarm_pkg::OFS_BOTTOM: begin
          if (nv <= level_alarm_pkg::FULL_SCALE) nxt.bot_thr = nv;
        end
        level_alarm_pkg::OFS_STOP: begin
          if (nv <= level_alarm_pkg::FULL_SCALE && nv > nxt.start_thr) nxt.stop_thr = nv;
        end
        level_alarm_pkg::OFS_START: begin
          if (nv < nxt.stop_thr) nxt.start_thr = nv;
        end
        level_alarm_pkg::OFS_INTERVAL: begin
          if (nv <= level_alarm_pkg::INTERVAL_MAX) nxt.interval = nv;
        end
        default: begin
        end
      endcase
    end

    // Span restore from storage and write-back of changes
    if (nv_restore && nv_restore_span >= level_alarm_pkg::SPAN_MIN &&
        nv_restore_span <= level_alarm_pkg::SPAN_MAX) begin
      nxt.span = nv_restore_span;
    end
    nxt.nvw = (nxt.span != st.span) && !nv_restore;

    // Fill valve control
    case (st.s2.fill)
      level_alarm_pkg::FILL_AUTO: begin
        case (st.fst)
          level_alarm_pkg::FILL_IDLE: begin
            if (level_valid && level < st.start_thr) begin
              nxt.fst      = level_alarm_pkg::FILL_ON;
              nxt.min_left = st.interval;
              nxt.min_ms   = 16'h0000;
            end
          end
          level_alarm_pkg::FILL_ON: begin
            if (level_valid && level >= st.stop_thr) begin
              nxt.fst      = level_alarm_pkg::FILL_IDLE;
              nxt.min_left = 10'h000;
            end else if (st.min_left != 10'h000 && st.tick_p) begin
              if (st.min_ms == level_alarm_pkg::MS_PER_MIN - 16'h0001) begin
                nxt.min_ms   = 16'h0000;
                nxt.min_left = st.min_left - 10'h001;
                if (st.min_left == 10'h001) nxt.fst = level_alarm_pkg::FILL_LOCK;
              end else begin
                nxt.min_ms = st.min_ms + 16'h0001;
              end
            end
          end
          level_alarm_pkg::FILL_LOCK: begin
          end
          default: nxt.fst = level_alarm_pkg::FILL_IDLE;
        endcase
      end
      level_alarm_pkg::FILL_OPEN: begin
        nxt.fst      = level_alarm_pkg::FILL_IDLE;
        nxt.min_left = 10'h000;
      end
      default: begin
        // Closed selector stops filling but keeps a lockout latched
        if (st.fst != level_alarm_pkg::FILL_LOCK) nxt.fst = level_alarm_pkg::FILL_IDLE;
        nxt.min_left = 10'h000;
      end
    endcase
    if (nxt.interval == 10'h000) begin
      nxt.min_left = 10'h000;
      if (nxt.fst == level_alarm_pkg::FILL_LOCK) nxt.fst = level_alarm_pkg::FILL_IDLE;
    end
    nxt.valve = st.s2.fill == level_alarm_pkg::FILL_OPEN ||
                (st.s2.fill == level_alarm_pkg::FILL_AUTO &&
                 nxt.fst == level_alarm_pkg::FILL_ON);
    nxt.fill_ind = nxt.valve;
    nxt.flash    = nxt.fst == level_alarm_pkg::FILL_LOCK;

    // Display value in percent tenths or length units
    prod = 26'(nxt.lvl) * 26'(nxt.span);
    if (fault) nxt.disp = 16'(level_alarm_pkg::FULL_SCALE);
    else if (nxt.show_ms != 16'h0000) nxt.disp = nxt.span;
    else if (st.s2.unit == level_alarm_pkg::UNIT_PCT) nxt.disp = 16'(nxt.lvl);
    else nxt.disp = 16'(prod / 26'(level_alarm_pkg::FULL_SCALE));
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st           <= '0;
      st.span      <= level_alarm_pkg::SPAN_RESET;
      st.up_thr    <= level_alarm_pkg::UP_RESET;
      st.bot_thr   <= level_alarm_pkg::BOT_RESET;
      st.stop_thr  <= level_alarm_pkg::STOP_RESET;
      st.start_thr <= level_alarm_pkg::START_RESET;
      st.interval  <= level_alarm_pkg::INTERVAL_RST;
      st.waitreq   <= 1'b1;
      st.startup   <= 1'b1;
    end else begin
      st <= nxt;
    end
  end

  assign readdata               = st.rdata;
  assign waitrequest            = st.waitreq;
  assign display_value          = st.disp;
  assign display_startup        = st.startup;
  assign display_flash          = st.flash;
  assign activity_led           = st.act;
  assign upper_alarm_indicator  = st.up_ind;
  assign bottom_alarm_indicator = st.bot_ind;
  assign upper_relay_coil       = st.up_coil;
  assign bottom_relay_coil      = st.bot_coil;
  assign fill_stop_indicator    = st.stop_ind;
  assign fill_start_indicator   = st.start_ind;
  assign fill_indicator         = st.fill_ind;
  assign fill_valve             = st.valve;
  assign buzzer                 = st.buzz;
  assign nv_write               = st.nvw;
  assign nv_span                = st.span;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  bus_answer_a: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus request not answered");
  upper_alarm_a: assert property (level_valid && level > st.up_thr |=>
    upper_alarm_indicator && !upper_relay_coil) else $error("upper alarm wrong");
  bottom_alarm_a: assert property (level_valid && level >= st.bot_thr |=>
    !bottom_alarm_indicator && bottom_relay_coil) else $error("bottom alarm wrong");
  silence_buzz_a: assert property (st.s2.mode == level_alarm_pkg::MODE_SILENCE
    |=> !buzzer) else $error("buzzer in silence");
  fill_closed_a: assert property (st.s2.fill == level_alarm_pkg::FILL_CLOSED
    |=> !fill_valve) else $error("valve on while closed");
  fill_open_a: assert property (st.s2.fill == level_alarm_pkg::FILL_OPEN
    |=> fill_valve && fill_indicator) else $error("valve off while open");
  band_order_a: assert property (st.stop_thr > st.start_thr)
    else $error("fill band reversed");
  thr_range_a: assert property (st.up_thr <= level_alarm_pkg::FULL_SCALE &&
    st.bot_thr <= level_alarm_pkg::FULL_SCALE &&
    st.interval <= level_alarm_pkg::INTERVAL_MAX) else $error("setting out of range");
  fault_show_a: assert property (st.quiet_ms == level_alarm_pkg::FAULT_MS &&
    !level_valid |=> display_value == 16'(level_alarm_pkg::FULL_SCALE) &&
    $stable(activity_led)) else $error("fault display wrong");
  span_pct_a: assert property (st.s2.unit == level_alarm_pkg::UNIT_PCT &&
    !nv_restore && !write ##1 st.s2.unit == level_alarm_pkg::UNIT_PCT && !nv_restore &&
    !write |=> $stable(st.span)) else $error("span moved in percent");
  lockout_a: assert property (st.fst == level_alarm_pkg::FILL_LOCK &&
    st.s2.fill == level_alarm_pkg::FILL_AUTO && nxt.interval != 10'h000 && !write
    |=> !fill_valve && display_flash) else $error("lockout not held");

  lock_seen_c: cover property (st.fst == level_alarm_pkg::FILL_LOCK);
  auto_fill_c: cover property (st.s2.fill == level_alarm_pkg::FILL_AUTO && fill_valve);
  bus_read_c:  cover property (read && !waitrequest);

endmodule : level_alarm_fill_controller

// file: dv/front_panel_model.sv
// Operator front panel and fill solenoid valve model
module front_panel_model (
  input  wire logic               clk,
  input  wire logic               fill_valve,
  output level_alarm_pkg::panel_t panel,
  output logic                    valve_open
);
  timeunit 1ns;
  timeprecision 1ns;
  // Switches start at run, percent units, fill closed
  initial panel = '0;
  // Valve opens while its solenoid is driven
  always_ff @(posedge clk) begin
    valve_open <= fill_valve;
  end
  // Operator moves switches just after a clock edge
  task automatic set_panel(input level_alarm_pkg::panel_t p);
    @(posedge clk);
    panel <= p;
  endtask : set_panel
endmodule : front_panel_model

// file: dv/level_alarm_fill_controller_test.sv
// Self-checking bench for the level alarm and fill controller
module level_alarm_fill_controller_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, reset_n, level_valid, read, write, waitrequest, valve_open;
  logic [9:0] level;
  logic [4:0] address;
  logic [31:0] writedata, readdata, q;
  level_alarm_pkg::panel_t panel;
  logic upi, boi, upc, boc, fsi, fti, fv, bz;
  logic [15:0] disp, nvs;
  logic act, fi, fl, su, nvw, nvr;
  int num_errors = 0;
  int cmp_count = 0;
  level_alarm_fill_controller #(.TICK_CYCLES(1)) uut (
    .clk(clk), .reset_n(reset_n), .panel(panel), .level_valid(level_valid), .level(level),
    .nv_restore(nvr), .nv_restore_span(16'h012c), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .display_value(disp), .display_startup(su), .display_flash(fl), .activity_led(act),
    .upper_alarm_indicator(upi), .bottom_alarm_indicator(boi), .upper_relay_coil(upc),
    .bottom_relay_coil(boc), .fill_stop_indicator(fsi), .fill_start_indicator(fti),
    .fill_indicator(fi), .fill_valve(fv), .buzzer(bz), .nv_write(nvw), .nv_span(nvs));
  front_panel_model pm (.clk(clk), .fill_valve(fv), .panel(panel), .valve_open(valve_open));
  // ----
  // Clock, verdict and comparison
  // ----
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic end_of_test();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // ----
  // Drivers
  // ----
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 100);
    if (n >= 100) chk(32'h1, 32'h0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus
  task automatic meas(input logic [9:0] v);
    @(posedge clk);
    level <= v;
    level_valid <= 1'b1;
    @(posedge clk);
    level_valid <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : meas
  task automatic sel(input level_alarm_pkg::fill_sel_t f, input level_alarm_pkg::mode_t m);
    level_alarm_pkg::panel_t p;
    p = '0;
    p.fill = f;
    p.mode = m;
    pm.set_panel(p);
    repeat (5) @(posedge clk);
  endtask : sel
  // ----
  // Scenarios
  // ----
  task automatic test_alarms();
    chk(su, 1); q[0] = act;
    meas(10'd901); chk(upi, 1); chk(upc, 0); chk(bz, 1); chk(act, !q[0]);
    meas(10'd900); chk(upi, 0); chk(upc, 1);
    meas(10'd99); chk(boi, 1); chk(fti, 1); chk(bz, 1);
    meas(10'd100); chk(boi, 0); chk(boc, 1);
    meas(10'd800); chk(fsi, 1); chk(fti, 0);
    meas(10'd799); chk(fsi, 0);
    sel(level_alarm_pkg::FILL_CLOSED, level_alarm_pkg::MODE_SILENCE);
    meas(10'd950); chk(bz, 0); chk(upi, 1);
    sel(level_alarm_pkg::FILL_CLOSED, level_alarm_pkg::MODE_RUN);
  endtask : test_alarms
  task automatic test_limits();
    bus(1'b0, level_alarm_pkg::OFS_INTERVAL, 0); chk(q, 0);
    bus(1'b1, level_alarm_pkg::OFS_START, 800);
    bus(1'b0, level_alarm_pkg::OFS_START, 0); chk(q, 200);
    bus(1'b1, level_alarm_pkg::OFS_UPPER, 1001);
    bus(1'b0, level_alarm_pkg::OFS_UPPER, 0); chk(q, 900);
    bus(1'b1, level_alarm_pkg::OFS_UPPER, 1000);
    bus(1'b0, level_alarm_pkg::OFS_UPPER, 0); chk(q, 1000);
  endtask : test_limits
  task automatic test_fill();
    meas(10'd150); chk(valve_open, 0);
    sel(level_alarm_pkg::FILL_AUTO, level_alarm_pkg::MODE_RUN);
    meas(10'd150); chk(valve_open, 1);
    meas(10'd500); chk(valve_open, 1);
    meas(10'd800); chk(valve_open, 0);
    sel(level_alarm_pkg::FILL_OPEN, level_alarm_pkg::MODE_RUN);
    chk(valve_open, 1); chk(fi, 1);
  endtask : test_fill
  task automatic test_panel();
    level_alarm_pkg::panel_t p;
    p = '0;
    bus(1'b1, level_alarm_pkg::OFS_SPAN, 200);
    @(posedge clk); chk(nvw, 1); chk(nvs, 200);
    bus(1'b0, level_alarm_pkg::OFS_UPPER, 0); chk(q, 1000);
    p.unit = level_alarm_pkg::UNIT_INCH;
    pm.set_panel(p);
    meas(10'd500); chk(disp, 100);
    p.mode = level_alarm_pkg::MODE_SPAN;
    p.raise = 1'b1;
    pm.set_panel(p);
    repeat (10) @(posedge clk);
    p.raise = 1'b0;
    pm.set_panel(p);
    repeat (5) @(posedge clk);
    chk(disp, 200); chk(nvs, 200);
    p.unit = level_alarm_pkg::UNIT_PCT;
    p.raise = 1'b1;
    pm.set_panel(p);
    repeat (600) @(posedge clk);
    chk(nvs, 200);
    p.raise = 1'b0;
    pm.set_panel(p);
    repeat (5) @(posedge clk);
    p.unit = level_alarm_pkg::UNIT_INCH;
    p.raise = 1'b1;
    pm.set_panel(p);
    repeat (600) @(posedge clk);
    chk(nvs, 201);
    repeat (1900) @(posedge clk);
    chk(nvs > 16'd208, 1); chk(su, 0);
    p.raise = 1'b0;
    pm.set_panel(p);
    repeat (5) @(posedge clk);
    nvr <= 1'b1;
    @(posedge clk);
    nvr <= 1'b0;
    @(posedge clk);
    chk(nvs, 16'h012c); chk(nvw, 0);
  endtask : test_panel
  task automatic test_timeout();
    bus(1'b1, level_alarm_pkg::OFS_INTERVAL, 1);
    sel(level_alarm_pkg::FILL_AUTO, level_alarm_pkg::MODE_RUN);
    meas(10'd150);
    repeat (59990) @(posedge clk);
    chk(fv, 1); chk(disp, 1000);
    repeat (10) @(posedge clk);
    chk(fv, 0); chk(fl, 1);
    sel(level_alarm_pkg::FILL_CLOSED, level_alarm_pkg::MODE_RUN);
    chk(fl, 1);
    sel(level_alarm_pkg::FILL_OPEN, level_alarm_pkg::MODE_RUN);
    chk(fl, 0); chk(fv, 1);
  endtask : test_timeout
  // ----
  // Main sequence and watchdog
  // ----
  initial begin
    {reset_n, level_valid, read, write, level, address, writedata, nvr} = '0;
    repeat (20) @(posedge clk);
    chk(upc, 0); chk(boc, 0);
    reset_n <= 1'b1;
    test_alarms();
    test_limits();
    test_fill();
    test_panel();
    test_timeout();
    end_of_test();
  end
  initial begin
    #300000;
    num_errors++;
    end_of_test();
  end
endmodule : level_alarm_fill_controller_test
